// File: toggle_timer_pkg.sv
// Purpose: shared constants of the auto-off timer block
// Assumes: 100 MHz system clock, AHB-Lite register access
// Notes:   all offsets are byte addresses of 32-bit words
`default_nettype none

package toggle_timer_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  STATUS_OFS    = 8'h04;
  localparam logic [7:0]  DELAY_OFS     = 8'h08;
  localparam logic [7:0]  REMAIN_OFS    = 8'h0C;
  localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

  // control bit: write 1 toggles the output like a touch
  localparam int          CTRL_TOGGLE   = 0;
  // status bits
  localparam int          ST_ON         = 0;
  localparam int          ST_X24        = 1;
  localparam int          ST_NO_AUTO    = 2;
  localparam int          ST_HOLD       = 3;
  localparam int          ST_BLOCK      = 4;
  localparam int          ST_RECAL      = 5;
  localparam int          ST_EXPIRED    = 6;
  localparam int          ST_SUSTAINED  = 7;

  // ****************************************
  // strap codes of the timeout pin
  // ****************************************
  localparam logic [1:0]  STRAP_GND     = 2'h0;
  localparam logic [1:0]  STRAP_VDD     = 2'h1;
  localparam logic [1:0]  STRAP_OUT     = 2'h2;
  localparam logic [1:0]  STRAP_RC      = 2'h3;

  // ****************************************
  // delays and timing
  // ****************************************
  localparam int          DLY_W         = 17;
  localparam int          MS_W          = 7;
  localparam int          SEC_PER_MIN   = 60;
  localparam int          DELAY_SHORT_MIN = 15;
  localparam int          DELAY_LONG_MIN  = 60;
  localparam logic [DLY_W-1:0] DELAY_SHORT_S = DLY_W'(DELAY_SHORT_MIN * SEC_PER_MIN);
  localparam logic [DLY_W-1:0] DELAY_LONG_S  = DLY_W'(DELAY_LONG_MIN * SEC_PER_MIN);
  localparam int          RC_STEP_S     = 15;
  localparam logic [7:0]  RC_MIN        = 8'h04;
  localparam logic [7:0]  RC_MAX        = 8'hF0;
  localparam int          MULT_HIGH     = 24;
  localparam logic [MS_W-1:0] SUSTAIN_EXTRA_MS = 7'h0A;
  localparam logic [MS_W-1:0] CANCEL_EXTRA_MS  = 7'h32;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          NS_PER_MS     = 1_000_000;
  localparam int          CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
  localparam int          MS_PER_S      = 1000;

endpackage : toggle_timer_pkg

`default_nettype wire

// File: tick_div.sv
// Purpose: divides a step strobe down to a one-cycle tick
// Assumes: DIV of at least one
// Notes:   tick_o comes one cycle after the DIV-th step
`default_nettype none

module tick_div #(
  parameter int unsigned DIV = 1000
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic step_i,
  output var  logic tick_o
);

  localparam int W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         nxt_tick;

  // ****************************************
  // divider
  // ****************************************
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (step_i) begin
      if (cnt_ff == LAST) begin
        nxt_cnt  = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_o <= nxt_tick;
    end
  end

endmodule // tick_div

`default_nettype wire

// File: touch_toggle_auto_off_timer.sv
// Purpose: auto-off timer of a one-key toggle switch, with sustain and cancel override
// Assumes: straps and touch events synchronous to clk_sys_i; AHB-Lite, no wait states
// Notes:   straps are caught once, in the first cycle after reset release
//
// Operation
// - active-low output: ground 15 min, supply no auto-off, output pin 60 min.
// - active-high output: ground no auto-off, supply 15 min, output pin 60 min.
// - multiplier line low gives x1, high gives x24 on the base delay.
// - multiplier caught once at power-up; later sampled per acquisition end for overrides.
// - RC strap with x1: delay is measured value times 15 seconds.
// - RC value outside 4..240 falls back to the matching hard-wired option.
// - delay expiring while on turns the output off without touch.
// - override longer than burst plus 10 ms reloads the delay counter while on.
// - override longer than burst plus 50 ms forces off, blocks touch until return.
// - while override is held, acquisition bursts are suspended.
// - on line return, recalibrate then resume in the current output state.
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`default_nettype none

module touch_toggle_auto_off_timer #(
  parameter int unsigned CYC_PER_MS = toggle_timer_pkg::CYC_PER_MS
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output var  logic [31:0] hrdata_o,
  output var  logic        hreadyout_o,
  output var  logic        hresp_o,
  // straps and sensor side
  input  wire logic        out_polarity_low_i,
  input  wire logic [1:0]  timeout_strap_level_i,
  input  wire logic [7:0]  rc_value_i,
  input  wire logic        multiplier_line_level_i,
  input  wire logic        touch_toggle_i,
  input  wire logic        acq_cycle_end_i,
  input  wire logic        recal_done_i,
  output var  logic        out_pin_o,
  output var  logic        burst_inhibit_o,
  output var  logic        touch_block_o,
  output var  logic        recal_req_o
);

  typedef enum logic [1:0] {OVR_IDLE, OVR_HOLD, OVR_RECAL} ovr_state_e;

  logic                  ms_tick;
  logic                  sec_tick;

  // ****************************************
  // time base
  // ****************************************
  tick_div #(.DIV(CYC_PER_MS)) u_ms_div (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .step_i    (1'b1),
    .tick_o    (ms_tick)
  );

  tick_div #(.DIV(toggle_timer_pkg::MS_PER_S)) u_sec_div (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .step_i    (ms_tick),
    .tick_o    (sec_tick)
  );

  // ****************************************
  // strap capture and delay selection
  // ****************************************
  logic                  taken_ff,  nxt_taken;
  logic                  act_low_ff, nxt_act_low;
  logic [1:0]            strap_ff,  nxt_strap;
  logic [7:0]            rc_ff,     nxt_rc;
  logic                  mult_ff,   nxt_mult;
  logic                  no_auto;
  logic [toggle_timer_pkg::DLY_W-1:0] base_s;
  logic [toggle_timer_pkg::DLY_W-1:0] delay_s;

  always_comb begin
    nxt_taken   = 1'b1;
    nxt_act_low = act_low_ff;
    nxt_strap   = strap_ff;
    nxt_rc      = rc_ff;
    nxt_mult    = mult_ff;
    if (!taken_ff) begin
      nxt_act_low = out_polarity_low_i;
      nxt_strap   = timeout_strap_level_i;
      nxt_rc      = rc_value_i;
      nxt_mult    = multiplier_line_level_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      taken_ff   <= 1'b0;
      act_low_ff <= 1'b0;
      strap_ff   <= toggle_timer_pkg::STRAP_GND;
      rc_ff      <= 8'h00;
      mult_ff    <= 1'b0;
    end else begin
      taken_ff   <= nxt_taken;
      act_low_ff <= nxt_act_low;
      strap_ff   <= nxt_strap;
      rc_ff      <= nxt_rc;
      mult_ff    <= nxt_mult;
    end
  end

  always_comb begin
    no_auto = 1'b0;
    base_s  = toggle_timer_pkg::DELAY_LONG_S;
    case (strap_ff)
      toggle_timer_pkg::STRAP_GND: begin
        no_auto = !act_low_ff;
        base_s  = toggle_timer_pkg::DELAY_SHORT_S;
      end
      toggle_timer_pkg::STRAP_VDD: begin
        no_auto = act_low_ff;
        base_s  = toggle_timer_pkg::DELAY_SHORT_S;
      end
      toggle_timer_pkg::STRAP_OUT: begin
        base_s  = toggle_timer_pkg::DELAY_LONG_S;
      end
      toggle_timer_pkg::STRAP_RC: begin
        // low values read as the output tie, high ones as the off-level tie
        if (rc_ff < toggle_timer_pkg::RC_MIN) begin
          base_s  = toggle_timer_pkg::DELAY_LONG_S;
        end else if (rc_ff > toggle_timer_pkg::RC_MAX) begin
          no_auto = 1'b1;
        end else begin
          base_s  = toggle_timer_pkg::DLY_W'(rc_ff * toggle_timer_pkg::RC_STEP_S);
        end
      end
      default: begin
        no_auto = 1'b1;
      end
    endcase
    // x24 scale, fits 17 bits for the largest base
    delay_s = mult_ff ? toggle_timer_pkg::DLY_W'(base_s * toggle_timer_pkg::MULT_HIGH)
                      : base_s;
  end

  // ****************************************
  // override sequencer
  // ****************************************
  ovr_state_e                       st_ff,   nxt_st;
  logic [toggle_timer_pkg::MS_W-1:0] ms_ff,  nxt_ms;
  logic                             block_ff, nxt_block;
  logic                             reload_evt;
  logic                             cancel_evt;
  logic                             line_away;

  assign line_away = multiplier_line_level_i != mult_ff;

  always_comb begin
    nxt_st     = st_ff;
    nxt_ms     = ms_ff;
    nxt_block  = block_ff;
    reload_evt = 1'b0;
    cancel_evt = 1'b0;
    case (st_ff)
      OVR_IDLE: begin
        // a pulse shorter than a burst is caught only if it spans an acquisition end
        // override sampling at acquisition end only
        if (taken_ff && acq_cycle_end_i && line_away) begin
          nxt_st = OVR_HOLD;
          nxt_ms = '0;
        end
      end
      OVR_HOLD: begin
        if (!line_away) begin
          nxt_st    = OVR_RECAL;
          nxt_block = 1'b0;
        end else if (ms_tick && ms_ff != '1) begin
          nxt_ms = ms_ff + toggle_timer_pkg::MS_W'(1);
          if (nxt_ms == toggle_timer_pkg::SUSTAIN_EXTRA_MS) begin
            reload_evt = 1'b1;
          end
          if (nxt_ms == toggle_timer_pkg::CANCEL_EXTRA_MS) begin
            cancel_evt = 1'b1;
            nxt_block  = 1'b1;
          end
        end
      end
      OVR_RECAL: begin
        if (recal_done_i) begin
          nxt_st = OVR_IDLE;
        end
      end
      default: begin
        nxt_st = OVR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff           <= OVR_IDLE;
      ms_ff           <= '0;
      block_ff        <= 1'b0;
      burst_inhibit_o <= 1'b0;
      touch_block_o   <= 1'b0;
      recal_req_o     <= 1'b0;
    end else begin
      st_ff           <= nxt_st;
      ms_ff           <= nxt_ms;
      block_ff        <= nxt_block;
      // bursts held off through the hold
      burst_inhibit_o <= nxt_st == OVR_HOLD;
      touch_block_o   <= nxt_block;
      recal_req_o     <= nxt_st == OVR_RECAL;
    end
  end

  // ****************************************
  // ahb-lite slave, zero wait states
  // ****************************************
  logic        acc;
  logic        mapped;
  logic        wr_ph_ff, nxt_wr_ph;
  logic [7:0]  addr_ff,  nxt_addr;
  logic [31:0] nxt_rdata;
  logic [31:0] status_w;
  logic        wr_ctrl;
  logic        wr_status;
  logic        on_ff;
  logic [toggle_timer_pkg::DLY_W-1:0] remain_ff;
  logic        expired_ff;
  logic        sustained_ff;

  assign acc    = hsel_i && hready_i && htrans_i[1];
  assign mapped = haddr_i[31:4] == 28'h0000000 && haddr_i[1:0] == 2'h0;

  always_comb begin
    status_w                                = 32'h0000_0000;
    status_w[toggle_timer_pkg::ST_ON]        = on_ff;
    status_w[toggle_timer_pkg::ST_X24]       = mult_ff;
    status_w[toggle_timer_pkg::ST_NO_AUTO]   = no_auto;
    status_w[toggle_timer_pkg::ST_HOLD]      = st_ff == OVR_HOLD;
    status_w[toggle_timer_pkg::ST_BLOCK]     = block_ff;
    status_w[toggle_timer_pkg::ST_RECAL]     = st_ff == OVR_RECAL;
    status_w[toggle_timer_pkg::ST_EXPIRED]   = expired_ff;
    status_w[toggle_timer_pkg::ST_SUSTAINED] = sustained_ff;
    nxt_wr_ph = acc && hwrite_i && mapped;
    nxt_addr  = acc ? haddr_i[7:0] : addr_ff;
    nxt_rdata = toggle_timer_pkg::RDATA_RESET;
    if (acc && !hwrite_i && mapped) begin
      case (haddr_i[7:0])
        toggle_timer_pkg::STATUS_OFS: nxt_rdata = status_w;
        toggle_timer_pkg::DELAY_OFS:  nxt_rdata = 32'(delay_s);
        toggle_timer_pkg::REMAIN_OFS: nxt_rdata = 32'(remain_ff);
        default:                      nxt_rdata = toggle_timer_pkg::RDATA_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ph_ff    <= 1'b0;
      addr_ff     <= 8'h00;
      hrdata_o    <= toggle_timer_pkg::RDATA_RESET;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_ph_ff    <= nxt_wr_ph;
      addr_ff     <= nxt_addr;
      hrdata_o    <= nxt_rdata;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  assign wr_ctrl   = wr_ph_ff && addr_ff == toggle_timer_pkg::CTRL_OFS;
  assign wr_status = wr_ph_ff && addr_ff == toggle_timer_pkg::STATUS_OFS;

  // ****************************************
  // output state and delay counter
  // ****************************************
  logic        nxt_on;
  logic [toggle_timer_pkg::DLY_W-1:0] nxt_remain;
  logic        nxt_expired;
  logic        nxt_sustained;
  logic        toggle_req;

  always_comb begin
    nxt_on        = on_ff;
    nxt_remain    = remain_ff;
    // set beats clear: events below override the write-1 clear
    nxt_expired   = expired_ff &&
                    !(wr_status && hwdata_i[toggle_timer_pkg::ST_EXPIRED]);
    nxt_sustained = sustained_ff &&
                    !(wr_status && hwdata_i[toggle_timer_pkg::ST_SUSTAINED]);
    // touches only count between overrides and outside a cancel block
    toggle_req    = taken_ff && st_ff == OVR_IDLE && !block_ff &&
                    (touch_toggle_i || (wr_ctrl && hwdata_i[toggle_timer_pkg::CTRL_TOGGLE]));
    if (cancel_evt) begin
      nxt_on     = 1'b0;
      nxt_remain = '0;
    end else if (toggle_req) begin
      // load on turn-on, clear on turn-off
      nxt_on     = !on_ff;
      nxt_remain = on_ff ? '0 : delay_s;
    end else if (on_ff) begin
      if (reload_evt) begin
        nxt_remain    = delay_s;
        nxt_sustained = 1'b1;
      end else if (sec_tick && !no_auto && remain_ff != '0) begin
        nxt_remain = remain_ff - toggle_timer_pkg::DLY_W'(1);
        if (remain_ff == toggle_timer_pkg::DLY_W'(1)) begin
          nxt_on      = 1'b0;
          nxt_expired = 1'b1;
        end
      end
    end else begin
      nxt_remain = '0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      on_ff        <= 1'b0;
      remain_ff    <= '0;
      expired_ff   <= 1'b0;
      sustained_ff <= 1'b0;
      out_pin_o    <= 1'b0;
    end else begin
      on_ff        <= nxt_on;
      remain_ff    <= nxt_remain;
      expired_ff   <= nxt_expired;
      sustained_ff <= nxt_sustained;
      // pin level follows polarity strap; low until the straps are caught
      out_pin_o    <= nxt_on ^ nxt_act_low;
    end
  end

endmodule // touch_toggle_auto_off_timer

`default_nettype wire

// File: touch_toggle_auto_off_timer_checker.sv
// Purpose: port-level assertions of the auto-off timer
// Assumes: straps steady while out of reset
// Notes:   bound to every timer instance
`default_nettype none

module touch_toggle_auto_off_timer_checker #(
  parameter int unsigned CYC_PER_MS = toggle_timer_pkg::CYC_PER_MS
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic out_polarity_low_i,
  input wire logic touch_toggle_i,
  input wire logic acq_cycle_end_i,
  input wire logic recal_done_i,
  input wire logic out_pin_o,
  input wire logic burst_inhibit_o,
  input wire logic touch_block_o,
  input wire logic recal_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // ****************************************
  // sequences and properties
  // ****************************************
  sequence s_line_back;
    $fell(burst_inhibit_o);
  endsequence
  sequence s_idle_touch;
    touch_toggle_i && !burst_inhibit_o && !touch_block_o && !recal_req_o;
  endsequence

  property p_ready; hreadyout_o; endproperty
  property p_okay; !hresp_o; endproperty
  property p_inh_cause; $rose(burst_inhibit_o) |-> $past(acq_cycle_end_i); endproperty
  property p_block_off; $rose(touch_block_o) |-> out_pin_o == out_polarity_low_i; endproperty
  property p_block_hold;
    touch_block_o |-> burst_inhibit_o && out_pin_o == out_polarity_low_i;
  endproperty
  property p_recal; s_line_back |-> recal_req_o && !touch_block_o; endproperty
  property p_recal_end; recal_req_o && recal_done_i |=> !recal_req_o; endproperty
  property p_toggle; s_idle_touch |=> out_pin_o != $past(out_pin_o); endproperty

  a_ready: assert property (p_ready) else $error("hreadyout low");
  a_okay: assert property (p_okay) else $error("hresp not okay");
  a_inh_cause: assert property (p_inh_cause) else $error("hold without acq end");
  a_block_off: assert property (p_block_off) else $error("cancel left output on");
  a_block_hold: assert property (p_block_hold) else $error("block outside hold");
  a_recal: assert property (p_recal) else $error("no recal on return");
  a_recal_end: assert property (p_recal_end) else $error("recal request stuck");
  a_toggle: assert property (p_toggle) else $error("touch not toggling");
endmodule // touch_toggle_auto_off_timer_checker

bind touch_toggle_auto_off_timer touch_toggle_auto_off_timer_checker #(
  .CYC_PER_MS(CYC_PER_MS)
) i_touch_toggle_auto_off_timer_checker (
  .clk_sys_i, .rst_i, .hreadyout_o, .hresp_o, .out_polarity_low_i, .touch_toggle_i,
  .acq_cycle_end_i, .recal_done_i, .out_pin_o, .burst_inhibit_o, .touch_block_o,
  .recal_req_o
);

`default_nettype wire

// File: override_src.sv
// Purpose: external sustain and cancel source on the multiplier line
// Assumes: line sits at the strap level between pulses
// Notes:   pulse length in whole clock cycles
`default_nettype none

module override_src (
  input  wire logic clk_sys_i,
  input  wire logic strap_i,
  output var  logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic away;

  initial away = 1'b0;
  task pulse(input int n);
    @(posedge clk_sys_i) away <= 1'b1;
    repeat (n) @(posedge clk_sys_i);
    away <= 1'b0;
  endtask

  assign line_o = strap_i ^ away;
endmodule // override_src

`default_nettype wire

// File: touch_toggle_auto_off_timer_tb.sv
// Purpose: self-checking bench of the auto-off timer
// Assumes: one ms is one cycle to keep the run short
// Notes:   acquisition ends every four cycles
`default_nettype none

module touch_toggle_auto_off_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic pol; logic [1:0] s; logic [7:0] rc; logic m;
                         logic [16:0] dly;} cfg_s;
  logic        clk_sys_i, rst_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0]  htrans_i, timeout_strap_level_i;
  logic [2:0]  hsize_i;
  logic [7:0]  rc_value_i;
  logic        out_polarity_low_i, multiplier_line_level_i, strap_lvl, touch_toggle_i;
  logic        acq_cycle_end_i = 1'b0;
  logic        recal_done_i, out_pin_o, burst_inhibit_o, touch_block_o, recal_req_o;
  int          acq_n = 0;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          n;
  // dly zero marks no auto-off
  cfg_s        tab [10] = '{
    {1'h1, 2'h0, 8'h00, 1'h0, 17'h00384}, {1'h1, 2'h1, 8'h00, 1'h0, 17'h00000},
    {1'h1, 2'h2, 8'h00, 1'h0, 17'h00E10}, {1'h0, 2'h0, 8'h00, 1'h0, 17'h00000},
    {1'h0, 2'h1, 8'h00, 1'h0, 17'h00384}, {1'h0, 2'h2, 8'h00, 1'h0, 17'h00E10},
    {1'h1, 2'h2, 8'h00, 1'h1, 17'h15180}, {1'h0, 2'h3, 8'hF0, 1'h0, 17'h00E10},
    {1'h0, 2'h3, 8'h03, 1'h0, 17'h00E10}, {1'h0, 2'h3, 8'hF1, 1'h0, 17'h00000}};

  assign hready_i = hreadyout_o;
  touch_toggle_auto_off_timer #(.CYC_PER_MS(1)) i_touch_toggle_auto_off_timer (
    .clk_sys_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .out_polarity_low_i,
    .timeout_strap_level_i, .rc_value_i, .multiplier_line_level_i, .touch_toggle_i,
    .acq_cycle_end_i, .recal_done_i, .out_pin_o, .burst_inhibit_o, .touch_block_o,
    .recal_req_o);
  override_src i_override_src (.clk_sys_i, .strap_i(strap_lvl), .line_o(multiplier_line_level_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    acq_n <= acq_n + 1;
    acq_cycle_end_i <= (acq_n % 4 == 0);
  end

  // ****************************************
  // tasks
  // ****************************************
  task results;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask
  // single word transfer, waits on hready each phase
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    hsel_i <= 1'b1; haddr_i <= {24'h000000, a}; htrans_i <= 2'h2; hwrite_i <= w;
    do begin @(posedge clk_sys_i); k++; end while (hready_i !== 1'b1 && k < 20);
    hsel_i <= 1'b0; htrans_i <= 2'h0; hwdata_i <= wd;
    do begin @(posedge clk_sys_i); k++; end while (hready_i !== 1'b1 && k < 40);
    rd = hrdata_o;
    if (k >= 40) begin bad_count++; results(); end
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task pulse_in(input logic t);
    @(posedge clk_sys_i) if (t) touch_toggle_i <= 1'b1; else recal_done_i <= 1'b1;
    @(posedge clk_sys_i) begin touch_toggle_i <= 1'b0; recal_done_i <= 1'b0; end
    #1;
  endtask
  task boot(input cfg_s c);
    rst_i <= 1'b1; out_polarity_low_i <= c.pol; timeout_strap_level_i <= c.s;
    rc_value_i <= c.rc; strap_lvl <= c.m;
    cyc(3);
    rst_i <= 1'b0;
    cyc(3);
  endtask
  function logic [31:0] b(input logic v);
    return {31'h0, v};
  endfunction

  // ****************************************
  // tests
  // ****************************************
  initial begin
    hsel_i = 1'b0; haddr_i = 32'h0; htrans_i = 2'h0; hwrite_i = 1'b0; hsize_i = 3'h2;
    hwdata_i = 32'h0; touch_toggle_i = 1'b0; recal_done_i = 1'b0;
    foreach (tab[i]) begin
      boot(tab[i]);
      chk(b(out_pin_o), b(tab[i].pol));
      if (tab[i].dly != 17'h0) rd_chk(toggle_timer_pkg::DELAY_OFS, {15'h0, tab[i].dly});
      rd_chk(toggle_timer_pkg::STATUS_OFS, {29'h0, tab[i].dly == 17'h0, tab[i].m, 1'b0});
    end
    $display("test straps done");
    boot({1'h0, 2'h3, 8'h04, 1'h0, 17'h0});
    rd_chk(toggle_timer_pkg::DELAY_OFS, 32'h3C);
    pulse_in(1'b1);
    chk(b(out_pin_o), 32'h1);
    rd_chk(toggle_timer_pkg::REMAIN_OFS, 32'h3C);
    n = 0;
    while (out_pin_o !== 1'b0 && n < 70000) begin @(posedge clk_sys_i); n++; end
    if (n >= 70000) begin bad_count++; results(); end
    chk(b(n > 58900 && n < 60100), 32'h1);
    rd_chk(toggle_timer_pkg::STATUS_OFS, 32'h40);
    ahb(1'b1, toggle_timer_pkg::STATUS_OFS, 32'h40);
    rd_chk(toggle_timer_pkg::STATUS_OFS, 32'h0);
    $display("test expiry done");
    boot({1'h1, 2'h2, 8'h00, 1'h0, 17'h0});
    rd_chk(8'h10, 32'h0);
    ahb(1'b1, toggle_timer_pkg::DELAY_OFS, 32'h5);
    rd_chk(toggle_timer_pkg::DELAY_OFS, 32'hE10);
    ahb(1'b1, toggle_timer_pkg::CTRL_OFS, 32'h1);
    cyc(1100);
    chk(b(out_pin_o), 32'h0);
    rd_chk(toggle_timer_pkg::REMAIN_OFS, 32'hE0F);
    i_override_src.pulse(30);
    cyc(2);
    chk(b(recal_req_o), 32'h1);
    pulse_in(1'b0);
    rd_chk(toggle_timer_pkg::REMAIN_OFS, 32'hE10);
    rd_chk(toggle_timer_pkg::STATUS_OFS, 32'h81);
    fork
      i_override_src.pulse(80);
      begin
        cyc(70);
        chk({30'h0, burst_inhibit_o, touch_block_o}, 32'h3);
        pulse_in(1'b1);
        chk(b(out_pin_o), 32'h1);
      end
    join
    cyc(2);
    chk({30'h0, touch_block_o, recal_req_o}, 32'h1);
    pulse_in(1'b1);
    chk(b(out_pin_o), 32'h1);
    pulse_in(1'b0);
    pulse_in(1'b1);
    chk(b(out_pin_o), 32'h0);
    $display("test override done");
    results();
  end
endmodule // touch_toggle_auto_off_timer_tb

`default_nettype wire
